// ### design/pca_pkg.sv
// Package for the packet configuration and auto-sequence block
// Assumes a 32-bit AXI4-Lite master and a packet datapath on aclk
package pca_pkg;

  // ************************************************************
  // Register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] PCA_IDX_PKT_CFG   = 8'h37;
  localparam logic [7:0] PCA_IDX_BODY_LEN  = 8'h38;
  localparam logic [7:0] PCA_IDX_OWN_ID    = 8'h39;
  localparam logic [7:0] PCA_IDX_GROUP_ID  = 8'h3A;
  localparam logic [7:0] PCA_IDX_AUTO_CFG  = 8'h3B;
  localparam logic [7:0] PCA_IDX_OP_MODE   = 8'h50;
  localparam logic [7:0] PCA_IDX_FLAGS     = 8'h51;
  localparam logic [7:0] PCA_IDX_IRQ_STAT  = 8'h52;
  localparam logic [7:0] PCA_IDX_IRQ_EN    = 8'h53;
  localparam logic [7:0] PCA_IDX_IRQ_CLR   = 8'h54;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PCA_POS_FORMAT    = 7;
  localparam int PCA_POS_CODING    = 5;
  localparam int PCA_POS_CRC_EN    = 4;
  localparam int PCA_POS_CRC_KEEP  = 3;
  localparam int PCA_POS_MATCH     = 1;
  localparam int PCA_POS_ENTRY     = 5;
  localparam int PCA_POS_EXIT      = 2;
  localparam int PCA_POS_TRANSIT   = 0;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] PCA_RST_PKT_CFG  = 8'h10;
  localparam logic [7:0] PCA_RST_BODY_LEN = 8'h40;
  localparam logic [7:0] PCA_RST_STATION  = 8'h00;
  localparam logic [7:0] PCA_RST_AUTO_CFG = 8'h00;
  localparam logic [1:0] PCA_RST_OP_MODE  = 2'b01;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0] PCA_MATCH_NONE  = 2'b00;
  localparam logic [1:0] PCA_MATCH_OWN   = 2'b01;
  localparam logic [1:0] PCA_MATCH_GROUP = 2'b10;
  localparam logic [2:0] PCA_EV_OFF      = 3'b000;
  localparam logic [1:0] PCA_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PCA_RESP_SLVERR = 2'b10;
  localparam int         PCA_NUM_IRQ     = 5;
  localparam int         PCA_NUM_EDGE    = 7;

  typedef enum logic [1:0]
  {
    PCA_AUTO_IDLE    = 2'b01,
    PCA_AUTO_TRANSIT = 2'b10
  } pca_auto_e;

  // Configuration handed to the datapath
  typedef struct packed
  {
    logic       length_format_select;
    logic [1:0] line_coding_select;
    logic       checksum_enable;
    logic       tx_len_fixed;
    logic [7:0] body_byte_count;
  } pca_cfg_s;

  // Status flags, bit order is the edge detector order
  typedef struct packed
  {
    logic timeout;
    logic tx_frame_done;
    logic frame_start_match;
    logic rx_body_complete;
    logic checksum_pass_flag;
    logic queue_above_threshold;
    logic queue_has_data;
  } pca_flags_s;

  // Register decode used by read and write paths
  function automatic logic pca_reg_hit(input logic [7:0] idx);
    pca_reg_hit = (idx >= PCA_IDX_PKT_CFG && idx <= PCA_IDX_AUTO_CFG) ||
                  (idx >= PCA_IDX_OP_MODE && idx <= PCA_IDX_IRQ_CLR);
  endfunction

endpackage

// ### design/pca_edge_detect.sv
// Rising and falling edge pulses for a group of status flags
// Assumes flags come from logic on the same clock
`timescale 1ns/100ps
module pca_edge_detect
  import pca_pkg::*;
#(
  parameter int N = PCA_NUM_EDGE
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);
  logic [N-1:0] prev_q;

  // ************************************************************
  // One flop and two gates per flag
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_q <= '0;
    else
      prev_q <= level;
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_edge
      assign rise[g] = level[g] & ~prev_q[g];
      assign fall[g] = ~level[g] & prev_q[g];
    end
  endgenerate
endmodule

// ### design/pca_axil_slave.sv
// AXI4-Lite slave front end with one word per register index
// Assumes the top decodes indices and supplies read data
`timescale 1ns/100ps
module pca_axil_slave
  import pca_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_en,
  output logic [7:0]       wr_idx,
  output logic [7:0]       wr_data,
  output logic [7:0]       rd_idx,
  output logic             rd_en,
  input  wire logic [7:0]  rd_data
);
  logic        aw_held_q;
  logic        w_held_q;
  logic [31:0] awaddr_q;
  logic [7:0]  wdata_q;
  logic        wlane_q;
  logic        wr_ok;
  logic        rd_ok;

  assign awready = ~aw_held_q & ~bvalid;
  assign wready  = ~w_held_q & ~bvalid;
  assign arready = ~rvalid;
  assign wr_ok   = awaddr_q[1:0] == 2'b00 && awaddr_q[31:10] == '0 &&
                   pca_reg_hit(awaddr_q[9:2]);
  assign rd_ok   = araddr[1:0] == 2'b00 && araddr[31:10] == '0 &&
                   pca_reg_hit(araddr[9:2]);
  assign wr_en   = aw_held_q & w_held_q & ~bvalid & wr_ok & wlane_q;
  assign wr_idx  = awaddr_q[9:2];
  assign wr_data = wdata_q;
  assign rd_idx  = araddr[9:2];
  assign rd_en   = arvalid & arready & rd_ok;

  // ************************************************************
  // Write channel
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wlane_q   <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= PCA_RESP_OKAY;
    end
    else if (bvalid)
    begin
      if (bready)
        bvalid <= 1'b0;
    end
    else if (aw_held_q && w_held_q)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid    <= 1'b1;
      bresp     <= wr_ok ? PCA_RESP_OKAY : PCA_RESP_SLVERR;
    end
    else
    begin
      if (awvalid && !aw_held_q)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && !w_held_q)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
      end
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= PCA_RESP_OKAY;
    end
    else if (rvalid)
    begin
      if (rready)
        rvalid <= 1'b0;
    end
    else if (arvalid)
    begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_ok ? rd_data : 8'h00};
      rresp  <= rd_ok ? PCA_RESP_OKAY : PCA_RESP_SLVERR;
    end
  end
endmodule

// ### design/pca_top.sv
// Packet configuration, receive checks and automatic mode sequencing
// Assumes an AXI4-Lite master and a packet datapath on aclk
`timescale 1ns/100ps
module pca_top
  import pca_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [6:0]          queue_count,
  input  wire logic [6:0]          queue_threshold,
  input  wire logic                rx_end_valid,
  input  wire logic                rx_crc_good,
  input  wire logic                rx_addr_valid,
  input  wire logic [7:0]          rx_addr_byte,
  input  wire logic                rx_len_valid,
  input  wire logic [7:0]          rx_len_byte,
  input  wire logic                frame_start_match,
  input  wire logic                tx_frame_done,
  input  wire logic                timeout,
  output pca_pkg::pca_cfg_s        cfg_q,
  output pca_pkg::pca_flags_s      flags_q,
  output logic [1:0]               op_mode_q,
  output logic                     auto_sequence_flag_q,
  output logic                     fifo_flush_q,
  output logic                     rx_restart_q,
  output logic                     addr_accept_q,
  output logic                     addr_reject_q,
  output logic                     len_reject_q,
  output logic                     irq_q
);
  logic [7:0]              pkt_cfg_q;
  logic [7:0]              body_len_q;
  logic [7:0]              own_station_id_q;
  logic [7:0]              group_station_id_q;
  logic [7:0]              auto_cfg_q;
  logic [1:0]              user_mode_q;
  logic [PCA_NUM_IRQ-1:0]  irq_stat_q;
  logic [PCA_NUM_IRQ-1:0]  irq_en_q;
  logic [PCA_NUM_IRQ-1:0]  irq_ev;
  logic                    wr_en;
  logic [7:0]              wr_idx;
  logic [7:0]              wr_data;
  logic [7:0]              rd_idx;
  logic [7:0]              rd_data;
  logic [PCA_NUM_EDGE-1:0] rise;
  logic [PCA_NUM_EDGE-1:0] fall;
  pca_auto_e               auto_q;
  logic                    crc_en;
  logic                    crc_keep;
  logic [1:0]              match_mode;
  logic [2:0]              auto_entry_event;
  logic [2:0]              auto_exit_event;
  logic [1:0]              transit_op_mode;
  logic                    auto_on;
  logic                    entry_hit;
  logic                    exit_hit;
  logic                    crc_bad;
  logic                    queue_empty;
  logic                    addr_ok;

  // ************************************************************
  // Field views
  // ************************************************************
  assign crc_en           = pkt_cfg_q[PCA_POS_CRC_EN];
  assign crc_keep         = pkt_cfg_q[PCA_POS_CRC_KEEP];
  assign match_mode       = pkt_cfg_q[PCA_POS_MATCH +: 2];
  assign auto_entry_event = auto_cfg_q[PCA_POS_ENTRY +: 3];
  assign auto_exit_event  = auto_cfg_q[PCA_POS_EXIT +: 3];
  assign transit_op_mode  = auto_cfg_q[PCA_POS_TRANSIT +: 2];
  assign auto_on          = auto_entry_event != PCA_EV_OFF &&
                            auto_exit_event != PCA_EV_OFF;
  assign queue_empty      = queue_count == 7'h00;
  assign crc_bad          = rx_end_valid & crc_en & ~rx_crc_good;

  // ************************************************************
  // Bus front end
  // ************************************************************
  pca_axil_slave u_bus
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx),
    .rd_en   (),
    .rd_data (rd_data)
  );

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pkt_cfg_q          <= PCA_RST_PKT_CFG;
      body_len_q         <= PCA_RST_BODY_LEN;
      own_station_id_q   <= PCA_RST_STATION;
      group_station_id_q <= PCA_RST_STATION;
      auto_cfg_q         <= PCA_RST_AUTO_CFG;
      user_mode_q        <= PCA_RST_OP_MODE;
      irq_en_q           <= '0;
    end
    else if (wr_en)
    begin
      unique case (wr_idx)
        PCA_IDX_PKT_CFG:  pkt_cfg_q          <= wr_data;
        PCA_IDX_BODY_LEN: body_len_q         <= wr_data;
        PCA_IDX_OWN_ID:   own_station_id_q   <= wr_data;
        PCA_IDX_GROUP_ID: group_station_id_q <= wr_data;
        PCA_IDX_AUTO_CFG: auto_cfg_q         <= wr_data;
        PCA_IDX_OP_MODE:  user_mode_q        <= wr_data[1:0];
        PCA_IDX_IRQ_EN:   irq_en_q <= wr_data[PCA_NUM_IRQ-1:0];
        default:          ;
      endcase
    end
  end

  // ************************************************************
  // Configuration to datapath
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_q <= '0;
    else
    begin
      cfg_q.length_format_select <= pkt_cfg_q[PCA_POS_FORMAT];
      cfg_q.line_coding_select   <= pkt_cfg_q[PCA_POS_CODING +: 2];
      cfg_q.checksum_enable      <= crc_en;
      cfg_q.tx_len_fixed         <= ~pkt_cfg_q[PCA_POS_FORMAT];
      cfg_q.body_byte_count      <= body_len_q;
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb
  begin
    rd_data = 8'h00;
    unique case (rd_idx)
      PCA_IDX_PKT_CFG:  rd_data = pkt_cfg_q;
      PCA_IDX_BODY_LEN: rd_data = body_len_q;
      PCA_IDX_OWN_ID:   rd_data = own_station_id_q;
      PCA_IDX_GROUP_ID: rd_data = group_station_id_q;
      PCA_IDX_AUTO_CFG: rd_data = auto_cfg_q;
      PCA_IDX_OP_MODE:  rd_data = {6'h00, op_mode_q};
      PCA_IDX_FLAGS:    rd_data = {auto_sequence_flag_q, flags_q};
      PCA_IDX_IRQ_STAT: rd_data = {3'h0, irq_stat_q};
      PCA_IDX_IRQ_EN:   rd_data = {3'h0, irq_en_q};
      default:          rd_data = 8'h00;
    endcase
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_q <= '0;
    else
    begin
      flags_q.queue_has_data        <= ~queue_empty;
      flags_q.queue_above_threshold <= queue_count > queue_threshold;
      flags_q.frame_start_match     <= frame_start_match;
      flags_q.tx_frame_done         <= tx_frame_done;
      flags_q.timeout               <= timeout;
      if (rx_end_valid && crc_en && rx_crc_good)
        flags_q.checksum_pass_flag <= 1'b1;
      else if (queue_empty)
        flags_q.checksum_pass_flag <= 1'b0;
      if (rx_end_valid && (!crc_en || rx_crc_good || crc_keep))
        flags_q.rx_body_complete <= 1'b1;
      else if (queue_empty)
        flags_q.rx_body_complete <= 1'b0;
    end
  end

  // ************************************************************
  // Checksum failure handling
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {fifo_flush_q, rx_restart_q} <= 2'b00;
    else
      {fifo_flush_q, rx_restart_q} <= {2{crc_bad & ~crc_keep}};
  end

  // ************************************************************
  // Address and length checks
  // ************************************************************
  always_comb
  begin
    addr_ok = 1'b0;
    unique case (match_mode)
      PCA_MATCH_NONE:  addr_ok = 1'b1;
      PCA_MATCH_OWN:   addr_ok = rx_addr_byte == own_station_id_q;
      PCA_MATCH_GROUP: addr_ok = rx_addr_byte == own_station_id_q ||
                                 rx_addr_byte == group_station_id_q;
      default:         addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {addr_accept_q, addr_reject_q, len_reject_q} <= 3'b000;
    else
    begin
      addr_accept_q <= rx_addr_valid & addr_ok;
      addr_reject_q <= rx_addr_valid & ~addr_ok;
      len_reject_q  <= rx_len_valid & pkt_cfg_q[PCA_POS_FORMAT] &
                       (rx_len_byte > body_len_q);
    end
  end

  // ************************************************************
  // Automatic mode sequencing
  // ************************************************************
  pca_edge_detect #(.N(PCA_NUM_EDGE)) u_edge
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (flags_q),
    .rise    (rise),
    .fall    (fall)
  );

  always_comb
  begin
    entry_hit = 1'b0;
    if (auto_entry_event == 3'b111)
      entry_hit = fall[0];
    else if (auto_entry_event != PCA_EV_OFF)
      entry_hit = rise[auto_entry_event - 3'd1];
  end

  always_comb
  begin
    exit_hit = 1'b0;
    unique case (auto_exit_event)
      3'b001:  exit_hit = fall[0];
      3'b000:  exit_hit = 1'b0;
      3'b110:  exit_hit = rise[5];
      3'b111:  exit_hit = rise[6];
      default: exit_hit = rise[auto_exit_event - 3'd1] | rise[6];
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      auto_q <= PCA_AUTO_IDLE;
    else
    begin
      unique case (auto_q)
        PCA_AUTO_IDLE:
          if (auto_on && entry_hit)
            auto_q <= PCA_AUTO_TRANSIT;
        PCA_AUTO_TRANSIT:
          if (!auto_on || exit_hit)
            auto_q <= PCA_AUTO_IDLE;
        default:
          auto_q <= PCA_AUTO_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {op_mode_q, auto_sequence_flag_q} <= {PCA_RST_OP_MODE, 1'b0};
    else
    begin
      auto_sequence_flag_q <= auto_q == PCA_AUTO_TRANSIT;
      op_mode_q <= (auto_q == PCA_AUTO_TRANSIT) ?
                   transit_op_mode : user_mode_q;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign irq_ev = {len_reject_q,
                   fifo_flush_q,
                   rise[3],
                   auto_sequence_flag_q & (auto_q == PCA_AUTO_IDLE),
                   ~auto_sequence_flag_q & (auto_q == PCA_AUTO_TRANSIT)};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < PCA_NUM_IRQ; i++)
      begin
        if (irq_ev[i])
          irq_stat_q[i] <= 1'b1;
        else if (wr_en && wr_idx == PCA_IDX_IRQ_CLR && wr_data[i])
          irq_stat_q[i] <= 1'b0;
      end
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule

// ### testbench/pca_top_checker.sv
// Port checker for pca_top
// Assumes binding to pca_top on the single clock aclk
`timescale 1ns/100ps
module pca_top_checker
  import pca_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [6:0] queue_count,
  input wire logic [6:0] queue_threshold,
  input wire logic       rx_end_valid,
  input wire logic       rx_crc_good,
  input wire logic       rx_addr_valid,
  input wire logic       rx_len_valid,
  input wire pca_cfg_s   cfg_q,
  input wire pca_flags_s flags_q,
  input wire logic       fifo_flush_q,
  input wire logic       rx_restart_q,
  input wire logic       addr_accept_q,
  input wire logic       addr_reject_q,
  input wire logic       len_reject_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_FMT: assert property ($past(aresetn) && $past(aresetn, 2) |->
    cfg_q.tx_len_fixed == !cfg_q.length_format_select) else $error("fmt");
  AST_THR: assert property ($past(aresetn) |->
    flags_q.queue_above_threshold == ($past(queue_count) >
    $past(queue_threshold))) else $error("threshold flag");
  AST_NE: assert property ($past(aresetn) |->
    flags_q.queue_has_data == ($past(queue_count) != 7'h00))
    else $error("data flag");
  AST_FLUSH: assert property (fifo_flush_q |-> rx_restart_q &&
    $past(rx_end_valid && !rx_crc_good)) else $error("flush");
  AST_NOCMP: assert property (fifo_flush_q |->
    !$rose(flags_q.rx_body_complete)) else $error("completion on flush");
  AST_ADDR: assert property (addr_accept_q || addr_reject_q |->
    $past(rx_addr_valid) && !(addr_accept_q && addr_reject_q))
    else $error("addr verdict");
  AST_LEN: assert property (len_reject_q |-> $past(rx_len_valid) &&
    cfg_q.length_format_select) else $error("len reject");
  AST_BODY: assert property ($rose(flags_q.rx_body_complete) |->
    $past(rx_end_valid)) else $error("completion set");
  AST_CLR: assert property ($past(aresetn && queue_count == 7'h00 &&
    !rx_end_valid) |-> !flags_q.rx_body_complete) else $error("clear");
endmodule
bind pca_top pca_top_checker pca_top_checker_inst (.*);

// ### testbench/pca_host_model.sv
// Host model: AXI4-Lite master for register access
// Assumes a slave on aclk
`timescale 1ns/100ps
module pca_host_model
(
  input  wire logic        aclk,
  output logic [31:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [31:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] q,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    q = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// ### testbench/packet_config_auto_sequence_flag_test.sv
// Self-checking bench for pca_top
// Assumes pca_top, pca_host_model and the checker compiled first
`timescale 1ns/100ps
module packet_config_auto_sequence_flag_test;
  import pca_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_end_valid;
  logic rx_crc_good, rx_addr_valid, rx_len_valid, frame_start_match;
  logic tx_frame_done, timeout, auto_sequence_flag_q, fifo_flush_q;
  logic rx_restart_q, addr_accept_q, addr_reject_q, len_reject_q, irq_q;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode_q, r;
  logic [6:0]  queue_count, queue_threshold;
  logic [7:0]  rx_addr_byte, rx_len_byte, o, g, b;
  pca_cfg_s    cfg_q;
  pca_flags_s  flags_q;
  int          num_errors, comparisons, cyc, seed;
  logic [7:0]  rv [5] = '{8'h10, 8'h40, 8'h00, 8'h00, 8'h00};
  pca_top pca_top_inst (.*);
  pca_host_model pca_host_model_inst (.*);
  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    comparisons++;
    if (gv !== ev)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, gv, ev);
    end
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    pca_host_model_inst.rd(i, q, r);
    chk(q, {24'h0, e});
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    pca_host_model_inst.wr(i, d, r);
    repeat (2) @(posedge aclk);
  endtask
  task automatic pulse(input logic [2:0] k, input logic [7:0] v);
    @(posedge aclk);
    {rx_addr_valid, rx_len_valid, rx_end_valid} <= k;
    {rx_addr_byte, rx_len_byte} <= {v, v};
    @(posedge aclk);
    {rx_addr_valid, rx_len_valid, rx_end_valid} <= 3'h0;
    #1;
  endtask
  function automatic logic acc(input logic [1:0] m, input logic [7:0] v);
    return m == 2'h0 || v == o || (m == 2'h2 && v == g);
  endfunction
  task automatic end_sim;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    seed = 52887;
    {aresetn, rx_end_valid, rx_crc_good, rx_addr_valid, rx_len_valid} = '0;
    {queue_count, queue_threshold, rx_addr_byte, rx_len_byte} = '0;
    {frame_start_match, tx_frame_done, timeout} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rv[k]) rdc(PCA_IDX_PKT_CFG + 8'(k), rv[k]);
    pca_host_model_inst.rd(8'h10, q, r);
    chk(r, PCA_RESP_SLVERR);
    $display("reset values done");
    for (int m = 0; m < 3; m++)
    begin
      o = 8'($random(seed));
      g = 8'($random(seed));
      queue_threshold <= 7'($random(seed));
      wr(PCA_IDX_OWN_ID, o);
      wr(PCA_IDX_GROUP_ID, g);
      wr(PCA_IDX_PKT_CFG, 8'h10 | 8'(m << 1));
      rdc(PCA_IDX_GROUP_ID, g);
      for (int j = 0; j < 3; j++)
      begin
        b = (j == 0) ? o : (j == 1) ? g : 8'($random(seed));
        pulse(3'h4, b);
        chk({addr_accept_q, addr_reject_q}, {acc(2'(m), b), !acc(2'(m), b)});
      end
    end
    $display("address filter done");
    wr(PCA_IDX_BODY_LEN, 8'h0a);
    for (int c = 0; c < 3; c++)
    begin
      wr(PCA_IDX_PKT_CFG, 8'h80 | 8'(c << 5));
      chk(cfg_q, {3'(4 + c), 10'h00a});
      pulse(3'h2, 8'h09 + 8'(c));
      chk(len_reject_q, c == 2);
    end
    wr(PCA_IDX_PKT_CFG, 8'h10);
    pulse(3'h2, 8'hff);
    chk({cfg_q, len_reject_q}, 14'h0614);
    $display("length done");
    queue_count <= 7'h05;
    pulse(3'h1, 8'h00);
    chk({fifo_flush_q, rx_restart_q, flags_q.rx_body_complete}, 3'h6);
    wr(PCA_IDX_PKT_CFG, 8'h18);
    pulse(3'h1, 8'h00);
    @(posedge aclk);
    #1 chk({fifo_flush_q, flags_q.rx_body_complete, irq_q}, 3'h2);
    queue_count <= 7'h00;
    repeat (2) @(posedge aclk);
    #1 chk(flags_q.rx_body_complete, 1'h0);
    rx_crc_good <= 1'h1;
    pulse(3'h1, 8'h00);
    chk(flags_q[3:2], 2'h3);
    $display("checksum done");
    for (int k = 1; k < 8; k++)
    begin
      wr(PCA_IDX_AUTO_CFG, 8'(k << 5));
      rdc(PCA_IDX_AUTO_CFG, 8'(k << 5));
      wr(PCA_IDX_AUTO_CFG, 8'(k << 2));
      rdc(PCA_IDX_AUTO_CFG, 8'(k << 2));
    end
    wr(PCA_IDX_AUTO_CFG, 8'h06);
    queue_count <= 7'h05;
    repeat (6) @(posedge aclk);
    #1 chk({auto_sequence_flag_q, op_mode_q}, 3'h1);
    queue_count <= 7'h00;
    wr(PCA_IDX_IRQ_EN, 8'h01);
    wr(PCA_IDX_OP_MODE, 8'h03);
    wr(PCA_IDX_AUTO_CFG, 8'h26);
    queue_count <= 7'h05;
    repeat (6) @(posedge aclk);
    #1 chk({auto_sequence_flag_q, op_mode_q, irq_q}, 4'hd);
    wr(PCA_IDX_IRQ_CLR, 8'h01);
    chk(irq_q, 1'h0);
    queue_count <= 7'h00;
    repeat (6) @(posedge aclk);
    #1 chk({auto_sequence_flag_q, op_mode_q}, 3'h3);
    rdc(PCA_IDX_IRQ_STAT, 8'h1e);
    $display("auto sequence done");
    end_sim;
  end
endmodule
